// ==== idx_exec_regs.svh ====
// Purpose: Constants for the indexed move and push-literal executor
// Assumes: 12-bit data addresses, 16-bit instruction words
// Notes:   Protected and indirect addresses are plain parameters of the core map
`ifndef IDX_EXEC_REGS_SVH
`define IDX_EXEC_REGS_SVH

// ==========================================================
// Opcode prefixes
`define MOVE_W1_PREFIX      9'h1D7
`define MOVE_W2_PREFIX      4'hF
`define PUSH_PREFIX         8'hFA

// ==========================================================
// Field widths and data space
`define OFFSET_W            7
`define ADDR_W              12
`define ADDR_MAX            12'hFFF
`define READ_BLANK          8'h00
`define PTR_STEP            12'h001

// ==========================================================
// Protected destinations (core special registers)
`define ADDR_PC_LOW         12'hFF9
`define ADDR_RET_UPPER      12'hFFF
`define ADDR_RET_HIGH       12'hFFE
`define ADDR_RET_LOW        12'hFFD

// ==========================================================
// Indirect-access registers (three pointers, five ports each)
`define ADDR_IND0_LO        12'hFEB
`define ADDR_IND0_HI        12'hFEF
`define ADDR_IND1_LO        12'hFE3
`define ADDR_IND1_HI        12'hFE7
`define ADDR_IND2_LO        12'hFDB
`define ADDR_IND2_HI        12'hFDF

`endif

// ==== idx_exec_pkg.sv ====
// Purpose: Types for the indexed move and push-literal executor
// Assumes: Nothing beyond the header
// Notes:   Gray-coded state encoding
package idx_exec_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DEST   = 2'b01
    } exec_state_t;
endpackage : idx_exec_pkg

// ==== data_byte_latch.sv ====
// Purpose: Holds the byte read from the source location between the two move cycles
// Assumes: Single core clock, active-low async reset
// Notes:   Read data comes combinationally from memory, not from a register
`timescale 1ns/100ps
module data_byte_latch (
    input  wire logic       ref_clk,    // Core clock
    input  wire logic       reset_n,    // Async reset, active low
    input  wire logic       clk_en,     // Freeze when low
    input  wire logic       load,       // Capture strobe
    input  wire logic [7:0] load_data,  // Byte to capture
    output logic      [7:0] held_data   // Captured byte
);
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            held_data <= 8'h00;
        end else if (clk_en && load) begin
            held_data <= load_data;
        end
    end
endmodule : data_byte_latch

// ==== indexed_move_push_exec.sv ====
// Purpose: Executes the indexed-to-indexed move and the push-literal instructions
// Assumes: Decoder hands over each instruction word with instr_valid; memory read data for the
//          source is combinational in the cycle of word one, before mem_rd_addr shows it; core clock only
// Notes:   Status flags are never touched; pointer update is offered to the register file
//
// Operation
// [RULE_01] The move is two words: 1110 1011 1 plus source offset, then 1111 plus dest offset.
// [RULE_02] Source and destination addresses are the offsets added to stack pointer two.
// [RULE_03] Both addresses may reach any byte of the 4096-byte space with no banking.
// [RULE_04] The move never writes program counter low or the three return-top bytes.
// [RULE_05] A source address on an indirect-access register reads as 00h.
// [RULE_06] A destination address on an indirect-access register makes the move a no-op.
// [RULE_07] Push-literal writes its 8-bit literal at the address held in stack pointer two.
// [RULE_08] Push-literal then decrements stack pointer two by one.
// [RULE_09] The move takes two cycles, the push one; the second word is used in cycle two.
// [RULE_10] Neither instruction alters any arithmetic status flag.
`timescale 1ns/100ps
`include "idx_exec_regs.svh"
module indexed_move_push_exec (
    input  wire logic                ref_clk,         // Core clock, 50 MHz
    input  wire logic                reset_n,         // Async reset, active low
    input  wire logic                clk_en,          // Freeze all state when low
    input  wire logic                instr_valid,     // Instruction word present
    input  wire logic [15:0]         instr_word,      // Instruction word
    input  wire logic [11:0]         stack_pointer_two, // Current pointer value
    input  wire logic [7:0]          mem_rd_data,     // Data read at the source address, in the cycle of word one
    output logic                     mem_rd_en,       // Source read request
    output logic      [11:0]         mem_rd_addr,     // Source read address
    output logic                     mem_wr_en,       // Data write strobe
    output logic      [11:0]         mem_wr_addr,     // Data write address
    output logic      [7:0]          mem_wr_data,     // Data write value
    output logic                     ptr_wr_en,       // Pointer update strobe
    output logic      [11:0]         ptr_wr_data,     // New pointer value
    output logic                     status_wr_en,    // Status flag write, always low
    output logic                     busy,            // Move awaiting second word
    output logic                     done             // Instruction retired
);
    import idx_exec_pkg::*;

    // ======================================================
    // Address helpers
    function automatic logic [11:0] index_addr(input logic [11:0] base,
                                               input logic [6:0]  ofs);
        index_addr = base + {5'h00, ofs}; // RULE_02
    endfunction : index_addr

    function automatic logic is_indirect(input logic [11:0] a);
        is_indirect = (a >= `ADDR_IND0_LO && a <= `ADDR_IND0_HI) ||
                      (a >= `ADDR_IND1_LO && a <= `ADDR_IND1_HI) ||
                      (a >= `ADDR_IND2_LO && a <= `ADDR_IND2_HI);
    endfunction : is_indirect

    function automatic logic is_protected(input logic [11:0] a);
        is_protected = (a == `ADDR_PC_LOW) || (a == `ADDR_RET_UPPER) ||
                       (a == `ADDR_RET_HIGH) || (a == `ADDR_RET_LOW);
    endfunction : is_protected

    // Move destination may be written: not protected, not an indirect port
    function automatic logic dest_writable(input logic [11:0] a);
        dest_writable = !is_indirect(a) && !is_protected(a); // RULE_04 RULE_06
    endfunction : dest_writable

    // ======================================================
    // Decode
    exec_state_t state_q;
    logic [7:0]  src_byte;
    logic [7:0]  held_byte;
    logic        is_move_w1;
    logic        is_move_w2;
    logic        is_push;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic        take_word1;
    logic        take_word2;
    logic        take_push;
    logic        dst_open;

    assign is_move_w1 = instr_valid && (instr_word[15:7] == `MOVE_W1_PREFIX);   // RULE_01
    assign is_move_w2 = instr_valid && (instr_word[15:12] == `MOVE_W2_PREFIX);  // RULE_01
    assign is_push    = instr_valid && (instr_word[15:8] == `PUSH_PREFIX);      // RULE_07
    assign src_addr   = index_addr(stack_pointer_two, instr_word[6:0]);         // RULE_03
    assign dst_addr   = index_addr(stack_pointer_two, instr_word[6:0]);         // RULE_03
    assign src_byte   = is_indirect(src_addr) ? `READ_BLANK : mem_rd_data;      // RULE_05

    // Words accepted by the sequencer this cycle
    assign take_word1 = (state_q == ST_IDLE) && is_move_w1;                     // RULE_01
    assign take_word2 = (state_q == ST_DEST) && is_move_w2;                     // RULE_09
    assign take_push  = (state_q == ST_IDLE) && is_push;                        // RULE_07
    assign dst_open   = dest_writable(dst_addr);                                // RULE_04

    // Source byte held until word two arrives
    data_byte_latch u_src_latch (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .load      (take_word1),
        .load_data (src_byte),
        .held_data (held_byte)
    );

    // ======================================================
    // Sequencer
    // A push word arriving while a move waits is taken as its second word
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            case (state_q)
                ST_IDLE: begin
                    if (is_move_w1) begin
                        state_q <= ST_DEST; // RULE_09
                    end
                end
                ST_DEST: begin
                    if (is_move_w2) begin
                        state_q <= ST_IDLE; // RULE_09
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // Source read port
    // Memory answers in the same cycle; the address is reported a cycle later
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_rd_en   <= 1'b0;
            mem_rd_addr <= 12'h000;
        end else if (clk_en) begin
            mem_rd_en <= 1'b0;
            if (take_word1) begin
                mem_rd_en   <= 1'b1;
                mem_rd_addr <= src_addr;
            end
        end
    end

    // ======================================================
    // Data write strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_wr_en <= 1'b0;
        end else if (clk_en) begin
            if (take_word2) begin
                mem_wr_en <= dst_open; // RULE_04 RULE_06
            end else if (take_push) begin
                mem_wr_en <= 1'b1; // RULE_07
            end else begin
                mem_wr_en <= 1'b0;
            end
        end
    end

    // ======================================================
    // Data write address and value
    // Updated for a refused move too, so the port shows what was dropped
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_wr_addr <= 12'h000;
            mem_wr_data <= 8'h00;
        end else if (clk_en) begin
            if (take_word2) begin
                mem_wr_addr <= dst_addr; // RULE_02
                mem_wr_data <= held_byte;
            end else if (take_push) begin
                mem_wr_addr <= stack_pointer_two; // RULE_07
                mem_wr_data <= instr_word[7:0];
            end
        end
    end

    // ======================================================
    // Pointer update
    // Only the push steps the pointer; the move leaves it alone
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_wr_en   <= 1'b0;
            ptr_wr_data <= 12'h000;
        end else if (clk_en) begin
            ptr_wr_en <= 1'b0;
            if (take_push) begin
                ptr_wr_en   <= 1'b1;
                ptr_wr_data <= stack_pointer_two - `PTR_STEP; // RULE_08
            end
        end
    end

    // ======================================================
    // Status flags
    // Neither instruction touches the arithmetic flags
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_wr_en <= 1'b0;
        end else if (clk_en) begin
            status_wr_en <= 1'b0; // RULE_10
        end
    end

    // ======================================================
    // Busy between the two move words
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else if (clk_en) begin
            if (take_word1) begin
                busy <= 1'b1; // RULE_09
            end else if (take_word2) begin
                busy <= 1'b0; // RULE_09
            end
        end
    end

    // ======================================================
    // Retire pulse, one per finished instruction
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            done <= 1'b0;
        end else if (clk_en) begin
            done <= take_push || take_word2; // RULE_09
        end
    end

endmodule : indexed_move_push_exec

// ==== move_push_chk.sv ====
// Purpose: Port checker for the indexed move and push-literal executor
// Assumes: One clock, async active-low reset
// Notes:   Bound to the top module
`timescale 1ns/100ps
`include "idx_exec_regs.svh"
module move_push_chk (
    input wire logic        ref_clk,           // Clock
    input wire logic        reset_n,           // Reset, active low
    input wire logic        clk_en,            // Run enable
    input wire logic        instr_valid,       // Word present
    input wire logic [15:0] instr_word,        // Word
    input wire logic [11:0] stack_pointer_two, // Pointer
    input wire logic        mem_rd_en,         // Read strobe
    input wire logic [11:0] mem_rd_addr,       // Read address
    input wire logic        mem_wr_en,         // Write strobe
    input wire logic [11:0] mem_wr_addr,       // Write address
    input wire logic [7:0]  mem_wr_data,       // Write data
    input wire logic        ptr_wr_en,         // Pointer strobe
    input wire logic [11:0] ptr_wr_data,       // New pointer
    input wire logic        status_wr_en,      // Flag write
    input wire logic        busy,              // Move pending
    input wire logic        done               // Retired
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire        take = clk_en && instr_valid;
    wire        push = take && !busy && instr_word[15:8] == `PUSH_PREFIX;
    wire        mv1  = take && !busy && instr_word[15:7] == `MOVE_W1_PREFIX;
    wire        mv2  = take && busy && instr_word[15:12] == `MOVE_W2_PREFIX;
    wire [11:0] ea   = stack_pointer_two + {5'h00, instr_word[6:0]};
    wire        prot = ea inside {`ADDR_PC_LOW, [`ADDR_RET_LOW:`ADDR_RET_UPPER]};
    wire        ind  = ea inside {[`ADDR_IND2_LO:`ADDR_IND2_HI], [`ADDR_IND1_LO:`ADDR_IND1_HI],
                                  [`ADDR_IND0_LO:`ADDR_IND0_HI]};
    property p_push;
        push |=> mem_wr_en && done && mem_wr_addr == $past(stack_pointer_two) &&
                 mem_wr_data == $past(instr_word[7:0]);
    endproperty
    a_push: assert property (p_push) else $error("push write wrong");
    property p_ptr;
        push |=> ptr_wr_en && ptr_wr_data == $past(stack_pointer_two) - `PTR_STEP;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer decrement wrong");
    property p_src; mv1 |=> busy && mem_rd_en && mem_rd_addr == $past(ea) && !done; endproperty
    a_src: assert property (p_src) else $error("source address wrong");
    property p_dst; mv2 && !prot && !ind |=> mem_wr_en && mem_wr_addr == $past(ea); endproperty
    a_dst: assert property (p_dst) else $error("destination write wrong");
    property p_end;
        mv2 |=> done && !busy ##1 (done == $past(push) || !$past(clk_en));
    endproperty
    a_end: assert property (p_end) else $error("move not retired in cycle two");
    property p_ignore;
        take && !busy && !push && !mv1 |=> !done && !mem_wr_en && !busy;
    endproperty
    a_ignore: assert property (p_ignore) else $error("stray word acted on");
    property p_prot; mv2 && prot |=> !mem_wr_en; endproperty
    a_prot: assert property (p_prot) else $error("protected destination written");
    property p_ind; mv2 && ind |=> !mem_wr_en && !ptr_wr_en; endproperty
    a_ind: assert property (p_ind) else $error("indirect destination written");
    property p_flag; !status_wr_en; endproperty
    a_flag: assert property (p_flag) else $error("status flags written");
endmodule : move_push_chk

bind indexed_move_push_exec move_push_chk i_move_push_chk (.ref_clk, .reset_n, .clk_en,
    .instr_valid, .instr_word, .stack_pointer_two, .mem_rd_en, .mem_rd_addr, .mem_wr_en,
    .mem_wr_addr, .mem_wr_data, .ptr_wr_en, .ptr_wr_data, .status_wr_en, .busy, .done);

// ==== testbench.sv ====
// Purpose: Directed bench for the indexed move and push-literal executor
// Assumes: Combinational memory data driven with each word
// Notes:   clk_en dropped in one scenario, reset pulsed once mid-run
`timescale 1ns/100ps
`include "idx_exec_regs.svh"
module testbench;
    logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [11:0] stack_pointer_two = 12'h000, mem_rd_addr, mem_wr_addr, ptr_wr_data;
    logic [7:0]  mem_rd_data = 8'h00, mem_wr_data;
    logic mem_rd_en, mem_wr_en, ptr_wr_en, status_wr_en, busy, done;
    int n_mismatch = 0, check_count = 0;
    indexed_move_push_exec i_indexed_move_push_exec (.ref_clk, .reset_n, .clk_en, .instr_valid,
        .instr_word, .stack_pointer_two, .mem_rd_data, .mem_rd_en, .mem_rd_addr, .mem_wr_en,
        .mem_wr_addr, .mem_wr_data, .ptr_wr_en, .ptr_wr_data, .status_wr_en, .busy, .done);
    always #10 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input logic [15:0] w, input logic [11:0] sp, input logic [7:0] rd);
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        stack_pointer_two <= sp;
        mem_rd_data <= rd;
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        #1;
    endtask : step
    task automatic do_move(input logic [11:0] sp, input logic [6:0] zs, input logic [6:0] zd,
                           input logic [7:0] rd, input logic wr, input logic [7:0] dat);
        logic [11:0] a;
        a = sp + zs;
        step({`MOVE_W1_PREFIX, zs}, sp, rd);
        chk(busy, 1'b1);
        chk(mem_rd_addr, a);
        a = sp + zd;
        step({`MOVE_W2_PREFIX, 5'h15, zd}, sp, 8'h00);
        chk({done, busy, mem_wr_en, status_wr_en}, {2'b10, wr, 1'b0});
        if (wr) chk({mem_wr_addr, mem_wr_data}, {a, dat});
    endtask : do_move
    task t_push;
        step(16'hFA08, 12'h1EC, 8'h00);
        chk({mem_wr_en, mem_wr_addr, mem_wr_data}, {1'b1, 12'h1EC, 8'h08});
        chk({ptr_wr_en, ptr_wr_data, done}, {1'b1, 12'h1EB, 1'b1});
        step(16'hFA7E, 12'h000, 8'h00);
        chk({ptr_wr_data, mem_wr_addr, mem_wr_data}, {12'hFFF, 12'h000, 8'h7E});
    endtask : t_push
    task t_freeze;
        @(posedge ref_clk);
        clk_en <= 1'b0;
        step(16'hFA11, 12'h100, 8'h00);
        chk({mem_wr_en, ptr_wr_en, done}, 3'b000);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        step(16'hFA11, 12'h100, 8'h00);
        chk({mem_wr_en, mem_wr_addr, mem_wr_data}, {1'b1, 12'h100, 8'h11});
    endtask : t_freeze
    task t_reset_mid;
        step({`MOVE_W1_PREFIX, 7'h01}, 12'h200, 8'h44);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
        chk({busy, mem_rd_en, done}, 3'b000);
        step(16'hF002, 12'h200, 8'h00);
        chk({busy, done, mem_wr_en}, 3'b000);
    endtask : t_reset_mid
    task t_other_word;
        step(16'hEB05, 12'h080, 8'h33);
        chk({busy, done, mem_rd_en}, 3'b000);
    endtask : t_other_word
    task t_moves;
        do_move(12'h080, 7'h05, 7'h06, 8'h33, 1'b1, 8'h33);
        do_move(12'hFF0, 7'h7F, 7'h7F, 8'h5A, 1'b1, 8'h5A);
        do_move(12'hFE0, 7'h0B, 7'h20, 8'hA5, 1'b1, 8'h00);
        do_move(12'hFD0, 7'h01, 7'h0B, 8'h77, 1'b0, 8'h00);
        do_move(12'hF80, 7'h01, 7'h79, 8'h77, 1'b0, 8'h00);
        do_move(12'hF80, 7'h02, 7'h7D, 8'h77, 1'b0, 8'h00);
        do_move(12'hF80, 7'h03, 7'h7E, 8'h77, 1'b0, 8'h00);
        do_move(12'hF80, 7'h04, 7'h7F, 8'h77, 1'b0, 8'h00);
        do_move(12'hF80, 7'h5F, 7'h10, 8'hC3, 1'b1, 8'h00);
        do_move(12'hF80, 7'h05, 7'h63, 8'h77, 1'b0, 8'h00);
    endtask : t_moves
    task results;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_push();
        t_other_word();
        t_moves();
        t_freeze();
        t_reset_mid();
        results();
    end
    initial begin
        #100us;
        n_mismatch++;
        results();
    end
endmodule : testbench
